// *** stepper_pkg.sv ***
// Package of constants shared by the stepper step and direction control logic.
package stepper_pkg;

    // ************************************************************
    // Clock and timing.
    // ************************************************************
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned IDLE_TIME_MS  = 100;
    localparam int unsigned IDLE_CYCLES   = CLK_HZ / 1000 * IDLE_TIME_MS;
    localparam int unsigned MAX_STEP_KHZ  = 200;
    localparam int unsigned STEP_MIN_CYC  = CLK_HZ / (MAX_STEP_KHZ * 1000);
    localparam int unsigned BLINK_TIME_MS = 250;
    localparam int unsigned BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_TIME_MS;
    localparam int unsigned ACT_HOLD_MS   = 20;
    localparam int unsigned ACT_HOLD_CYC  = CLK_HZ / 1000 * ACT_HOLD_MS;

    // ************************************************************
    // Current and position encoding.
    // ************************************************************
    localparam int unsigned CUR_W       = 7;
    localparam logic [6:0]  CUR_BASE_DA = 7'h16;
    localparam logic [6:0]  CUR_STEP_DA = 7'h04;
    localparam int unsigned POS_W       = 32;
    localparam int unsigned RES_W       = 16;

    // ************************************************************
    // Fault bit positions.
    // ************************************************************
    localparam int unsigned F_UNDERV  = 0;
    localparam int unsigned F_OVERV   = 1;
    localparam int unsigned F_OPEN    = 2;
    localparam int unsigned F_OVERHT  = 3;
    localparam int unsigned F_OVERCUR = 4;
    localparam int unsigned F_ENCODER = 5;
    localparam int unsigned FAULT_W   = 6;

    // Microsteps per revolution for a 4-bit switch code, first switch in bit 3.
    function automatic logic [15:0] steps_per_rev(input logic [3:0] code);
        case (code)
            4'hF:    steps_per_rev = 16'h00C8;
            4'h7:    steps_per_rev = 16'h0190;
            4'hB:    steps_per_rev = 16'h0320;
            4'hD:    steps_per_rev = 16'h03E8;
            4'hE:    steps_per_rev = 16'h0640;
            4'h3:    steps_per_rev = 16'h07D0;
            4'hC:    steps_per_rev = 16'h0C80;
            4'h1:    steps_per_rev = 16'h0FA0;
            4'h8:    steps_per_rev = 16'h1388;
            4'h5:    steps_per_rev = 16'h1900;
            4'hA:    steps_per_rev = 16'h1F40;
            4'h6:    steps_per_rev = 16'h2710;
            4'h9:    steps_per_rev = 16'h3200;
            4'h4:    steps_per_rev = 16'h4E20;
            4'h2:    steps_per_rev = 16'h6400;
            default: steps_per_rev = 16'h9C40;
        endcase
    endfunction : steps_per_rev

endpackage : stepper_pkg

// *** edge_sync.sv ***
// Two-stage synchroniser with a registered falling-edge detector.
`timescale 1ns/100ps
module edge_sync (
    input  wire logic sys_clk,   // System clock.
    input  wire logic nrst,      // Asynchronous reset, active low.
    input  wire logic pin_in,    // Asynchronous pin level.
    output logic      level_out, // Synchronised level.
    output logic      fall_out   // One-cycle pulse on a falling edge.
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // Pins idle high, so reset to high to avoid a false edge at release.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_out = sync_ff;
    assign fall_out  = prev_ff & ~sync_ff;
endmodule : edge_sync

// *** stepper_step_dir_control.sv ***
// Step, direction, current and status control of a two-phase stepper driver.
//
// Overview of operation
// - One microstep per step falling edge
// - Direction level sets sense of each step in step-dir mode
// - Step rates up to 200 kHz accepted
// - Halve current after 100 ms idle
// - Resolution switches select 200 to 4000
// - Resolution switches select 5000 to 40000
// - Current switches pick sixteen levels 2.2-8.2 A
// - Mode switch selects step-dir or dual pulse
// - Motor free removes all coil current
// - Alarm output on supply, open, overheat faults
// - Activity lamp blinks idle, steady when stepping
// - Fault lamp blinks on any detected fault except overheat
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
module stepper_step_dir_control #(
    parameter int unsigned IDLE_CYC  = stepper_pkg::IDLE_CYCLES,
    parameter int unsigned BLINK_CYC = stepper_pkg::BLINK_CYCLES,
    parameter int unsigned HOLD_CYC  = stepper_pkg::ACT_HOLD_CYC
) (
    input  wire logic        sys_clk,             // 10 MHz system clock.
    input  wire logic        nrst,                // Asynchronous reset, active low.
    input  wire logic        step_pulse_in,       // Step pulse pin, falling edge acts.
    input  wire logic        direction_in,        // Direction pin, or CCW pulse pin.
    input  wire logic        motor_free_in,       // Motor free pin, active low.
    input  wire logic        current_select_0,    // Current switch one, ON=1.
    input  wire logic        current_select_1,    // Current switch two, ON=1.
    input  wire logic        current_select_2,    // Current switch three, ON=1.
    input  wire logic        current_select_3,    // Current switch four, ON=1.
    input  wire logic        resolution_select_0, // Resolution switch one, ON=1.
    input  wire logic        resolution_select_1, // Resolution switch two, ON=1.
    input  wire logic        resolution_select_2, // Resolution switch three, ON=1.
    input  wire logic        resolution_select_3, // Resolution switch four, ON=1.
    input  wire logic        input_mode_select,   // OFF step-dir, ON dual pulse.
    input  wire logic [5:0]  fault_in,            // Raw fault detector levels.
    input  wire logic [7:0]  reg_addr,            // Register address.
    input  wire logic [31:0] reg_wdata,           // Register write data.
    input  wire logic        reg_wr,              // Write strobe.
    input  wire logic        reg_rd,              // Read strobe.
    output logic [31:0]      reg_rdata,           // Read data, cycle after strobe.
    output logic [31:0]      position_out,        // Microstep position counter.
    output logic [15:0]      microstep_res_out,   // Microsteps per revolution.
    output logic [6:0]       current_da_out,      // Commanded current in 0.1 A.
    output logic             step_out,            // Pulse per taken microstep.
    output logic             step_dir_out,        // Sense of the last microstep, 1=CW.
    output logic             drive_en_out,        // Power stage enable.
    output logic             alarm_out,           // Alarm switch on, active high.
    output logic             act_lamp_out,        // Activity lamp.
    output logic             fault_lamp_out,      // Fault lamp.
    output logic             irq_out              // Interrupt level.
);
    // ************************************************************
    // Register map and status bit layout.
    // ************************************************************
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_MASK   = 8'h04;
    localparam logic [7:0] A_CTRL   = 8'h08;
    localparam logic [7:0] A_POS    = 8'h0C;
    localparam logic [7:0] A_SW     = 8'h10;
    localparam int unsigned ST_W    = 8;
    localparam int unsigned S_FAULT = 0;
    localparam int unsigned S_IDLE  = 1;
    localparam int unsigned S_FREE  = 2;
    localparam int unsigned S_RATE  = 3;

    typedef enum logic [1:0] {ST_FREE, ST_RUN, ST_HOLD} drive_state_t;

    // ************************************************************
    // Synchronisation of pins and switches.
    // ************************************************************
    logic       step_lvl, step_fall, dir_lvl, dir_fall, free_lvl;
    logic [9:0] sw_meta_ff, sw_ff;
    logic [5:0] flt_meta_ff, flt_ff;

    edge_sync u_step (.sys_clk(sys_clk), .nrst(nrst), .pin_in(step_pulse_in),
                      .level_out(step_lvl), .fall_out(step_fall));
    edge_sync u_dir  (.sys_clk(sys_clk), .nrst(nrst), .pin_in(direction_in),
                      .level_out(dir_lvl), .fall_out(dir_fall));
    edge_sync u_free (.sys_clk(sys_clk), .nrst(nrst), .pin_in(motor_free_in),
                      .level_out(free_lvl), .fall_out());

    // Switches and fault detectors are asynchronous levels, so two stages each.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sw_meta_ff  <= 10'h000;
            sw_ff       <= 10'h000;
            flt_meta_ff <= 6'h00;
            flt_ff      <= 6'h00;
        end else begin
            sw_meta_ff  <= {input_mode_select,
                            resolution_select_0, resolution_select_1,
                            resolution_select_2, resolution_select_3,
                            current_select_3, current_select_2,
                            current_select_1, current_select_0, 1'b0};
            sw_ff       <= sw_meta_ff;
            flt_meta_ff <= fault_in;
            flt_ff      <= flt_meta_ff;
        end
    end

    logic       dual_mode;
    logic [3:0] res_code;
    logic [3:0] cur_code;
    assign dual_mode = sw_ff[9];
    assign res_code  = sw_ff[8:5];
    assign cur_code  = sw_ff[4:1];

    logic step_req, step_cw;
    logic motor_free;
    assign motor_free = ~free_lvl;

    // In step-dir mode the direction level picks the sense; in dual mode each pin
    // carries its own sense. Both edges in one cycle cancel rather than guess.
    always_comb begin
        if (dual_mode) begin
            step_req = step_fall ^ dir_fall;
            step_cw  = step_fall;
        end else begin
            step_req = step_fall;
            step_cw  = dir_lvl;
        end
    end

    logic step_take;
    assign step_take = step_req & ~motor_free;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            position_out <= 32'h0000_0000;
            step_out     <= 1'b0;
            step_dir_out <= 1'b1;
        end else begin
            step_out <= step_take;
            if (step_take) begin
                step_dir_out <= step_cw;
                position_out <= step_cw ? position_out + 32'h0000_0001
                                        : position_out - 32'h0000_0001;
            end
        end
    end

    // Resolution is looked up through the shared table.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            microstep_res_out <= 16'h00C8;
        end else begin
            microstep_res_out <= stepper_pkg::steps_per_rev(res_code);
        end
    end

    // Spacing below the 200 kHz period is flagged but still stepped; the edge
    // detector itself keeps up with far faster input.
    logic [7:0]  gap_ff;
    logic        rate_evt;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gap_ff <= 8'hFF;
        end else if (step_req) begin
            gap_ff <= 8'h00;
        end else if (gap_ff != 8'hFF) begin
            gap_ff <= gap_ff + 8'h01;
        end
    end
    assign rate_evt = step_req && (gap_ff < 8'(stepper_pkg::STEP_MIN_CYC - 1));

    logic [31:0]  idle_cnt_ff;
    logic         idle_ff;
    drive_state_t state_ff, nxt_state;

    // Every taken pulse restarts the idle count.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_ff <= 32'h0000_0000;
            idle_ff     <= 1'b0;
        end else if (step_req) begin
            idle_cnt_ff <= 32'h0000_0000;
            idle_ff     <= 1'b0;
        end else if (idle_cnt_ff < IDLE_CYC) begin
            idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
        end else begin
            idle_ff     <= 1'b1;
        end
    end

    always_comb begin
        case (state_ff)
            ST_FREE: nxt_state = motor_free ? ST_FREE : ST_RUN;
            ST_RUN:  nxt_state = motor_free ? ST_FREE : (idle_ff ? ST_HOLD : ST_RUN);
            ST_HOLD: nxt_state = motor_free ? ST_FREE : (step_req ? ST_RUN : ST_HOLD);
            default: nxt_state = ST_FREE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_FREE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    logic [6:0] run_da;
    // Levels are evenly spaced 0.4 A apart from 2.2 A.
    assign run_da = stepper_pkg::CUR_BASE_DA
                  + 7'(cur_code * stepper_pkg::CUR_STEP_DA);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            current_da_out <= 7'h00;
            drive_en_out   <= 1'b0;
        end else begin
            case (nxt_state)
                ST_RUN: begin
                    current_da_out <= run_da;
                    drive_en_out   <= 1'b1;
                end
                ST_HOLD: begin
                    current_da_out <= {1'b0, run_da[6:1]};
                    drive_en_out   <= 1'b1;
                end
                default: begin
                    current_da_out <= 7'h00;
                    drive_en_out   <= 1'b0;
                end
            endcase
        end
    end

    logic alarm_cond, any_fault;
    assign alarm_cond = flt_ff[stepper_pkg::F_UNDERV] | flt_ff[stepper_pkg::F_OVERV]
                      | flt_ff[stepper_pkg::F_OPEN]   | flt_ff[stepper_pkg::F_OVERHT];
    assign any_fault  = flt_ff[stepper_pkg::F_UNDERV] | flt_ff[stepper_pkg::F_OVERV]
                      | flt_ff[stepper_pkg::F_OPEN]   | flt_ff[stepper_pkg::F_OVERCUR]
                      | flt_ff[stepper_pkg::F_ENCODER];

    logic [31:0] blink_cnt_ff, hold_cnt_ff;
    logic        blink_ff;
    // One shared blink phase keeps both lamps in step with each other.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            blink_cnt_ff <= 32'h0000_0000;
            blink_ff     <= 1'b0;
        end else if (blink_cnt_ff >= BLINK_CYC - 1) begin
            blink_cnt_ff <= 32'h0000_0000;
            blink_ff     <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
        end
    end

    // Activity is held a short while after each pulse so slow stepping looks steady.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold_cnt_ff <= 32'h0000_0000;
        end else if (step_req) begin
            hold_cnt_ff <= HOLD_CYC;
        end else if (hold_cnt_ff != 32'h0000_0000) begin
            hold_cnt_ff <= hold_cnt_ff - 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            alarm_out      <= 1'b0;
            act_lamp_out   <= 1'b0;
            fault_lamp_out <= 1'b0;
        end else begin
            alarm_out      <= alarm_cond;
            act_lamp_out   <= (step_req || hold_cnt_ff != 32'h0000_0000) | blink_ff;
            fault_lamp_out <= any_fault & blink_ff;
        end
    end

    // ************************************************************
    // Registers and interrupt.
    // ************************************************************
    logic [ST_W-1:0] status_ff, mask_ff, evt;
    logic            soft_free_ff;
    logic            any_fault_d_ff, idle_d_ff;

    always_comb begin
        evt          = '0;
        evt[S_FAULT] = any_fault & ~any_fault_d_ff;
        evt[S_IDLE]  = idle_ff & ~idle_d_ff;
        evt[S_FREE]  = motor_free & (state_ff != ST_FREE);
        evt[S_RATE]  = rate_evt;
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_ff      <= '0;
            any_fault_d_ff <= 1'b0;
            idle_d_ff      <= 1'b0;
        end else begin
            any_fault_d_ff <= any_fault;
            idle_d_ff      <= idle_ff;
            if (reg_wr && reg_addr == A_STATUS) begin
                status_ff <= (status_ff & ~reg_wdata[ST_W-1:0]) | evt;
            end else begin
                status_ff <= status_ff | evt;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mask_ff      <= '0;
            soft_free_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == A_MASK) mask_ff <= reg_wdata[ST_W-1:0];
            if (reg_addr == A_CTRL) soft_free_ff <= reg_wdata[0];
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads as zero.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                A_STATUS: reg_rdata <= {24'h00_0000, status_ff};
                A_MASK:   reg_rdata <= {24'h00_0000, mask_ff};
                A_CTRL:   reg_rdata <= {31'h0000_0000, soft_free_ff};
                A_POS:    reg_rdata <= position_out;
                A_SW:     reg_rdata <= {15'h0000, flt_ff, state_ff, sw_ff[9:1]};
                default:  reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_ff & mask_ff);
        end
    end
endmodule : stepper_step_dir_control

// *** motion_ctrl.sv ***
// Model of the motion controller that drives the step and direction lines.
`timescale 1ns/100ps
module motion_ctrl (
    input  wire logic sys_clk,       // System clock.
    output logic      step_pulse_in, // Step line, or clockwise line.
    output logic      direction_in   // Direction line, or counter-clockwise line.
);
    // Both lines start high; after a step-dir pulse the direction line rests at dir.
    initial begin
        step_pulse_in = 1'b1;
        direction_in  = 1'b1;
    end

    // One pulse; ccw picks the line, dir sets the sense in step-dir mode.
    task automatic pulse(input logic ccw, input logic dir);
        if (!ccw) begin
            direction_in <= dir;
        end
        repeat (10) @(posedge sys_clk); // Direction settles long before the edge.
        if (ccw) begin
            direction_in <= 1'b0;
        end else begin
            step_pulse_in <= 1'b0;
        end
        repeat (25) @(posedge sys_clk);
        step_pulse_in <= 1'b1;
        direction_in  <= ccw ? 1'b1 : dir;
        repeat (15) @(posedge sys_clk);
    endtask : pulse
endmodule : motion_ctrl

// *** stepper_chk.sv ***
// Port checker of the stepper step and direction control, with its bind.
`timescale 1ns/100ps
module stepper_chk #(
    parameter int unsigned IDLE_CYC = 200 // Pulse-free cycles before half current.
) (
    input wire logic        sys_clk,           // Clock.
    input wire logic        nrst,              // Reset, active low.
    input wire logic        step_pulse_in,     // Step line.
    input wire logic        direction_in,      // Direction line.
    input wire logic        motor_free_in,     // Motor free, active low.
    input wire logic        current_select_0,  // Current switch one.
    input wire logic        current_select_1,  // Current switch two.
    input wire logic        current_select_2,  // Current switch three.
    input wire logic        current_select_3,  // Current switch four.
    input wire logic        input_mode_select, // Mode switch.
    input wire logic [5:0]  fault_in,          // Fault levels.
    input wire logic [31:0] position_out,      // Position.
    input wire logic [6:0]  current_da_out,    // Commanded current.
    input wire logic        step_out,          // Step pulse.
    input wire logic        step_dir_out,      // Step sense.
    input wire logic        drive_en_out,      // Stage enable.
    input wire logic        alarm_out,         // Alarm.
    input wire logic        act_lamp_out,      // Activity lamp.
    input wire logic        fault_lamp_out     // Fault lamp.
);
    logic [6:0]  run_da;
    int unsigned idle_cnt_ff;
    assign run_da = 7'h16 + 7'h04 * {3'h0, current_select_3, current_select_2,
                                     current_select_1, current_select_0};

    // Saturating count of quiet cycles; freeing the motor restarts it.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_ff <= 0;
        end else if (step_out || !motor_free_in) begin
            idle_cnt_ff <= 0;
        end else if (idle_cnt_ff < IDLE_CYC + 16) begin
            idle_cnt_ff <= idle_cnt_ff + 1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_STEP_LATENCY: assert property (!input_mode_select && motor_free_in && $fell(step_pulse_in)
        |-> ##[2:4] step_out) else $error("step fall gave no step");
    AST_STEP_COUNT: assert property (step_out
        |-> position_out == $past(position_out) + (step_dir_out ? 32'h1 : 32'hFFFF_FFFF))
        else $error("position moved by other than one");
    AST_POS_QUIET: assert property (!step_out |-> $stable(position_out))
        else $error("position moved without a step");
    AST_DIR_LEVEL: assert property (step_out && !input_mode_select
        |-> step_dir_out == $past(direction_in, 3)) else $error("wrong step sense");
    AST_CCW_PULSE: assert property (input_mode_select && motor_free_in && $fell(direction_in)
        |-> ##[2:4] (step_out && !step_dir_out)) else $error("ccw fall gave no ccw step");
    AST_IDLE_HALF: assert property (idle_cnt_ff == IDLE_CYC + 12
        |-> current_da_out == run_da >> 1) else $error("idle current not halved");
    AST_RUN_RESTORE: assert property (step_out && motor_free_in
        |-> ##1 current_da_out == run_da) else $error("run current not restored");
    AST_FREE_CUT: assert property (!motor_free_in [*6]
        |-> current_da_out == 7'h00 && !drive_en_out) else $error("free motor still driven");
    AST_ALARM_ON: assert property ((fault_in[3:0] != 4'h0) [*5] |-> alarm_out)
        else $error("alarm missing");
    AST_ALARM_OFF: assert property ((fault_in[3:0] == 4'h0) [*5] |-> !alarm_out)
        else $error("alarm without cause");
    AST_LAMP_QUIET: assert property ((fault_in == 6'h00) [*5] |-> !fault_lamp_out)
        else $error("fault lamp without fault");
    AST_ACT_STEADY: assert property (step_out |-> ##3 act_lamp_out [*5])
        else $error("activity lamp not steady");
endmodule : stepper_chk

bind stepper_step_dir_control stepper_chk #(.IDLE_CYC(IDLE_CYC)) chk_i (.*);

// *** testbench.sv ***
// Self-checking bench of the stepper step and direction control.
`timescale 1ns/100ps
module testbench;
    localparam int unsigned IDLE = 200; // Shortened idle delay.
    logic        sys_clk = 1'b0;
    logic        nrst, motor_free_in, input_mode_select, reg_wr, reg_rd, irq_out;
    logic        step_pulse_in, direction_in, step_out, step_dir_out, drive_en_out;
    logic        alarm_out, act_lamp_out, fault_lamp_out;
    logic        current_select_0, current_select_1, current_select_2, current_select_3;
    logic        resolution_select_0, resolution_select_1;
    logic        resolution_select_2, resolution_select_3;
    logic [3:0]  res_code, cur_code;
    logic [5:0]  fault_in;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, position_out, exp_pos, rdat;
    logic [15:0] microstep_res_out;
    logic [6:0]  current_da_out;
    int          miscompares = 0;
    int          tests_run = 0;
    // Pulses per revolution indexed by the code {first, second, third, fourth}.
    logic [15:0] res_tab [16] = '{16'h9C40, 16'h0FA0, 16'h6400, 16'h07D0, 16'h4E20, 16'h1900,
        16'h2710, 16'h0190, 16'h1388, 16'h3200, 16'h1F40, 16'h0320, 16'h0C80, 16'h03E8,
        16'h0640, 16'h00C8};

    assign {resolution_select_0, resolution_select_1, resolution_select_2,
            resolution_select_3} = res_code;
    assign {current_select_3, current_select_2, current_select_1, current_select_0} = cur_code;
    always #50 sys_clk = ~sys_clk;

    stepper_step_dir_control #(.IDLE_CYC(IDLE), .BLINK_CYC(20), .HOLD_CYC(10)) DUT (.*);
    motion_ctrl ctl (.*);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : rd

    task automatic step(input logic ccw, input logic cw_dir);
        ctl.pulse(ccw, cw_dir);
        exp_pos = exp_pos + ((!ccw && cw_dir) ? 32'h1 : 32'hFFFF_FFFF);
        chk(position_out, exp_pos);
    endtask : step

    // A lamp that blinks is lit for part of a window of three half periods.
    task automatic blink(input logic fault_lamp, input logic exp);
        int hi;
        hi = 0;
        repeat (60) begin
            @(posedge sys_clk);
            hi += fault_lamp ? fault_lamp_out : act_lamp_out;
        end
        chk(hi > 10 && hi < 50, exp);
    endtask : blink

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        {nrst, reg_wr, reg_rd, input_mode_select} = 4'h0;
        {fault_in, reg_addr, reg_wdata} = '0;
        motor_free_in = 1'b1;
        cur_code = 4'h0;
        res_code = 4'hF;
        exp_pos = 32'h0;
        repeat (4) @(posedge sys_clk);
        chk(microstep_res_out, 16'h00C8);
        nrst <= 1'b1;
        cyc(8);
        for (int i = 0; i < 16; i++) begin
            res_code <= 4'(i);
            cyc(5);
            chk(microstep_res_out, res_tab[i]);
        end
        step(1'b0, 1'b1);
        for (int i = 0; i < 16; i++) begin
            cur_code <= 4'(i);
            cyc(5);
            chk(current_da_out, 22 + 4 * i);
        end
        // Every step reverses the sense, at the highest allowed pulse rate.
        for (int i = 0; i < 4; i++) begin
            step(1'b0, i[0]);
            chk(step_dir_out, i[0]);
        end
        rd(8'h00, rdat);
        chk(rdat[3], 1'b0);
        wr(8'h0C, 32'h0000_FFFF);
        rd(8'h0C, rdat);
        chk(rdat, exp_pos);
        wr(8'h08, 32'h1);
        rd(8'h08, rdat);
        chk(rdat[0], 1'b1);
        rd(8'h40, rdat);
        chk(rdat, 32'h0);
        input_mode_select <= 1'b1;
        cyc(5);
        step(1'b0, 1'b1);
        step(1'b1, 1'b0);
        chk(step_dir_out, 1'b0);
        input_mode_select <= 1'b0;
        wr(8'h04, 32'h2);
        cyc(IDLE + 20);
        chk(current_da_out, 7'h29);
        chk(irq_out, 1'b1);
        blink(1'b0, 1'b1);
        rd(8'h00, rdat);
        chk(rdat[1], 1'b1);
        wr(8'h00, 32'h2);
        cyc(2);
        chk(irq_out, 1'b0);
        step(1'b0, 1'b1);
        chk(current_da_out, 7'h52);
        motor_free_in <= 1'b0;
        cyc(8);
        chk(current_da_out, 7'h00);
        chk(drive_en_out, 1'b0);
        ctl.pulse(1'b0, 1'b1);
        chk(position_out, exp_pos);
        motor_free_in <= 1'b1;
        for (int b = 0; b < 6; b++) begin
            fault_in <= 6'(1 << b);
            cyc(6);
            chk(alarm_out, b < 4);
            blink(1'b1, b != stepper_pkg::F_OVERHT);
        end
        fault_in <= 6'h00;
        cyc(4);
        stop_test();
    end

    // The sequence needs about 1,330 cycles; fifteen times that means a hang.
    initial begin
        #2_000_000;
        miscompares++;
        stop_test();
    end
endmodule : testbench
